/* File: include/adcc_pkg.sv */
// Constants, types and register map of the converter control block.
// Assumes a single system clock and an 8-bit register port.
package adcc_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam logic [2:0] OFF_RES_HIGH = 3'h0;
  localparam logic [2:0] OFF_RES_LOW = 3'h1;
  localparam logic [2:0] OFF_CONTROL = 3'h2;
  localparam logic [2:0] OFF_CLK_PWR = 3'h3;
  localparam logic [2:0] OFF_PIN_EN = 3'h4;
  localparam logic [2:0] OFF_IRQ_STAT = 3'h5;
  localparam logic [2:0] OFF_IRQ_MASK = 3'h6;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int START_BIT = 7;
  localparam int RUN_BIT = 6;
  localparam int PWR_OFF_BIT = 6;
  localparam int REF_SEL_BIT = 5;
  localparam int CLK_SEL_HI = 2;
  localparam int CHAN_HI = 3;
  localparam int HIGH_BYTE_LO = 4;
  localparam int RESULT_W = 12;
  localparam int LOW_PAD_W = 4;
  localparam logic [3:0] TOP_BIT_IDX = 4'hB;
  localparam logic [11:0] FIRST_TRIAL = 12'h800;
  // ----------------------------------------------------------------
  // Reset values and divider
  // ----------------------------------------------------------------
  localparam logic RUN_RESET = 1'b1;
  localparam logic PWR_OFF_RESET = 1'b1;
  localparam logic [7:0] PIN_EN_RESET = 8'h00;
  localparam logic [7:0] DIV_BASE = 8'h02;
  localparam logic [7:0] DIV_ONE = 8'h01;
  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_ARMED = 3'b010,
    ST_CONV = 3'b100
  } adcc_state_type;
endpackage

/* File: include/adcc_if.sv */
// Link between the control block and its approximation sequencer.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface adcc_if;
  logic go;
  logic clr;
  logic cken;
  logic comp;
  logic done;
  logic [11:0] code;
  modport ctl (output go, output clr, output cken, output comp, input done, input code);
  modport sar (input go, input clr, input cken, input comp, output done, output code);
endinterface

/* File: verilog/adcc_sar.sv */
// Successive approximation sequencer, one result bit per converter clock.
// Assumes a comparator that is high while the input is at or above the trial code.
`timescale 1ns/1ps
module adcc_sar
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Control link
  adcc_if.sar link
);
  typedef struct packed
  {
    logic busy;
    logic [3:0] idx;
    logic [11:0] code;
    logic done;
  } adcc_sar_type;

  adcc_sar_type q;
  adcc_sar_type d;

  always_comb
  begin
    d = q;
    d.done = 1'b0;
    if (link.clr)
    begin
      d.busy = 1'b0;
      d.code = '0;
    end
    else if (link.go && !q.busy)
    begin
      d.busy = 1'b1;
      d.idx = adcc_pkg::TOP_BIT_IDX;
      d.code = adcc_pkg::FIRST_TRIAL;
    end
    else if (q.busy && link.cken)
    begin
      if (!link.comp)
      begin
        d.code[q.idx] = 1'b0;
      end
      if (q.idx == 4'h0)
      begin
        d.busy = 1'b0;
        d.done = 1'b1;
      end
      else
      begin
        d.idx = 4'(q.idx - 4'h1);
        d.code[4'(q.idx - 4'h1)] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign link.done = q.done;
  assign link.code = q.code;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_clr_idle;
    @(posedge clk_in) disable iff (rst_in)
    link.clr |=> !q.busy && !q.done;
  endproperty
  a_clr_idle: assert property (p_clr_idle) else $error("sequencer busy after reset");
endmodule

/* File: verilog/adcc_top.sv */
// Converter control and result registers around one 12-bit converter.
// Assumes an external comparator, trial-code DAC and analog channel mux.
`timescale 1ns/1ps
module adcc_top
#(
  parameter bit WIDE_VARIANT = 1'b1
)
(
  // Clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic SYS_RST_IN,
  // Register port
  input wire logic [2:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [7:0] REG_RDATA_OUT,
  // Analog front end
  input wire logic COMP_IN,
  output logic [11:0] DAC_CODE_OUT,
  output logic [3:0] CHAN_SEL_OUT,
  output logic CONV_RESET_OUT,
  output logic CONV_POWER_OFF_OUT,
  output logic REF_SELECT_OUT,
  // Pin function control
  input wire logic [7:0] PULLUP_CFG_IN,
  output logic [7:0] PIN_ANALOG_EN_OUT,
  output logic [7:0] PIN_DIGITAL_EN_OUT,
  output logic [7:0] PIN_PULLUP_EN_OUT,
  // Interrupt
  output logic IRQ_OUT
);
  localparam logic [3:0] CHAN_MASK = WIDE_VARIANT ? 4'hF : 4'h7;
  localparam logic [7:0] PIN_MASK = WIDE_VARIANT ? 8'hFF : 8'h3F;

  typedef struct packed
  {
    adcc_pkg::adcc_state_type st;
    logic start;
    logic run;
    logic [3:0] chan;
    logic pwr_off;
    logic ref_sel;
    logic [2:0] clk_sel;
    logic [7:0] pin_en;
    logic [11:0] res;
    logic stat;
    logic mask;
    logic irq;
    logic [7:0] rdata;
    logic [7:0] div;
    logic cken;
    logic go;
    logic clr;
    logic [3:0] sel_out;
    logic [7:0] dig_en;
    logic [7:0] pull_en;
  } adcc_top_type;

  adcc_top_type q;
  adcc_top_type d;
  adcc_if link ();

  function automatic logic fn_hit(input logic strobe, input logic [2:0] addr, input logic [2:0] off);
    fn_hit = strobe && (addr == off);
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d = q;
    d.cken = 1'b0;
    d.go = 1'b0;
    // Converter clock divider.
    if (q.pwr_off)
    begin
      d.div = '0;
    end
    else if (q.div >= 8'((adcc_pkg::DIV_BASE << q.clk_sel) - adcc_pkg::DIV_ONE))
    begin
      d.div = '0;
      d.cken = 1'b1;
    end
    else
    begin
      d.div = 8'(q.div + adcc_pkg::DIV_ONE);
    end
    // Register writes.
    // no write path to result
    if (fn_hit(REG_WR_IN, REG_ADDR_IN, adcc_pkg::OFF_CONTROL))
    begin
      d.chan = REG_WDATA_IN[adcc_pkg::CHAN_HI:0] & CHAN_MASK;
      d.start = REG_WDATA_IN[adcc_pkg::START_BIT];
    end
    if (fn_hit(REG_WR_IN, REG_ADDR_IN, adcc_pkg::OFF_CLK_PWR))
    begin
      d.pwr_off = REG_WDATA_IN[adcc_pkg::PWR_OFF_BIT];
      d.ref_sel = REG_WDATA_IN[adcc_pkg::REF_SEL_BIT];
      d.clk_sel = REG_WDATA_IN[adcc_pkg::CLK_SEL_HI:0];
    end
    if (fn_hit(REG_WR_IN, REG_ADDR_IN, adcc_pkg::OFF_PIN_EN))
    begin
      d.pin_en = REG_WDATA_IN & PIN_MASK;
    end
    if (fn_hit(REG_WR_IN, REG_ADDR_IN, adcc_pkg::OFF_IRQ_MASK))
    begin
      d.mask = REG_WDATA_IN[0];
    end
    if (d.start && !q.start)
    begin
      d.st = adcc_pkg::ST_ARMED;
      d.run = 1'b1;
    end
    else
    begin
      unique case (q.st)
        adcc_pkg::ST_IDLE:
        begin
          d.st = adcc_pkg::ST_IDLE;
        end
        adcc_pkg::ST_ARMED:
        begin
          if (!d.start)
          begin
            d.st = adcc_pkg::ST_CONV;
            d.go = 1'b1;
          end
        end
        adcc_pkg::ST_CONV:
        begin
          if (link.done)
          begin
            d.st = adcc_pkg::ST_IDLE;
            d.run = 1'b0;
            d.res = link.code;
          end
        end
        default:
        begin
          d.st = adcc_pkg::ST_IDLE;
        end
      endcase
    end
    d.clr = (d.st == adcc_pkg::ST_ARMED);
    // Done status: a read clears it, a new completion wins.
    if (fn_hit(REG_RD_IN, REG_ADDR_IN, adcc_pkg::OFF_IRQ_STAT))
    begin
      d.stat = 1'b0;
    end
    if (link.done && q.st == adcc_pkg::ST_CONV && !(d.start && !q.start))
    begin
      d.stat = 1'b1;
    end
    d.irq = d.stat && d.mask;
    d.sel_out = d.chan;
    d.dig_en = ~d.pin_en;
    d.pull_en = PULLUP_CFG_IN & ~d.pin_en;
    // Read data, valid the cycle after the strobe.
    d.rdata = '0;
    if (REG_RD_IN)
    begin
      unique case (REG_ADDR_IN)
        adcc_pkg::OFF_RES_HIGH:
        begin
          d.rdata = q.res[adcc_pkg::RESULT_W-1:adcc_pkg::HIGH_BYTE_LO];
        end
        adcc_pkg::OFF_RES_LOW:
        begin
          d.rdata = {q.res[adcc_pkg::HIGH_BYTE_LO-1:0], {adcc_pkg::LOW_PAD_W{1'b0}}};
        end
        adcc_pkg::OFF_CONTROL:
        begin
          d.rdata = {q.start, q.run, 2'h0, q.chan};
        end
        adcc_pkg::OFF_CLK_PWR:
        begin
          d.rdata = {1'b0, q.pwr_off, q.ref_sel, 2'h0, q.clk_sel};
        end
        adcc_pkg::OFF_PIN_EN:
        begin
          d.rdata = q.pin_en;
        end
        adcc_pkg::OFF_IRQ_STAT:
        begin
          d.rdata = {7'h00, q.stat};
        end
        adcc_pkg::OFF_IRQ_MASK:
        begin
          d.rdata = {7'h00, q.mask};
        end
        default:
        begin
          d.rdata = '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      q <= '0;
      q.st <= adcc_pkg::ST_IDLE;
      q.run <= adcc_pkg::RUN_RESET;
      q.pwr_off <= adcc_pkg::PWR_OFF_RESET;
      q.pin_en <= adcc_pkg::PIN_EN_RESET;
      q.dig_en <= ~adcc_pkg::PIN_EN_RESET;
    end
    else
    begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  assign link.go = q.go;
  assign link.clr = q.clr;
  assign link.cken = q.cken;
  assign link.comp = COMP_IN;

  adcc_sar u_sar
  (
    .clk_in(SYS_CLK_IN),
    .rst_in(SYS_RST_IN),
    .link(link.sar)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign REG_RDATA_OUT = q.rdata;
  assign DAC_CODE_OUT = link.code;
  assign CHAN_SEL_OUT = q.sel_out;
  assign CONV_RESET_OUT = q.clr;
  assign CONV_POWER_OFF_OUT = q.pwr_off;
  assign REF_SELECT_OUT = q.ref_sel;
  assign PIN_ANALOG_EN_OUT = q.pin_en;
  assign PIN_DIGITAL_EN_OUT = q.dig_en;
  assign PIN_PULLUP_EN_OUT = q.pull_en;
  assign IRQ_OUT = q.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (SYS_RST_IN);

  property p_result_ro;
    (REG_WR_IN && (REG_ADDR_IN == adcc_pkg::OFF_RES_HIGH || REG_ADDR_IN == adcc_pkg::OFF_RES_LOW)
      && !link.done) |=> $stable(q.res);
  endproperty
  a_result_ro: assert property (p_result_ro) else $error("result changed by a write");

  property p_high_byte;
    (REG_RD_IN && REG_ADDR_IN == adcc_pkg::OFF_RES_HIGH) |=> REG_RDATA_OUT == $past(q.res[11:4]);
  endproperty
  a_high_byte: assert property (p_high_byte) else $error("high byte misaligned");

  property p_low_pad;
    (REG_RD_IN && REG_ADDR_IN == adcc_pkg::OFF_RES_LOW) |=> REG_RDATA_OUT[3:0] == 4'h0
      && REG_RDATA_OUT[7:4] == $past(q.res[3:0]);
  endproperty
  a_low_pad: assert property (p_low_pad) else $error("low byte padding wrong");

  property p_result_load;
    (link.done && q.st == adcc_pkg::ST_CONV && !(d.start && !q.start)) |=> q.res == $past(link.code);
  endproperty
  a_result_load: assert property (p_result_load) else $error("result not loaded");

  property p_chan_width;
    (REG_WR_IN && REG_ADDR_IN == adcc_pkg::OFF_CONTROL)
      |=> CHAN_SEL_OUT == ($past(REG_WDATA_IN[adcc_pkg::CHAN_HI:0]) & CHAN_MASK)
      && (CHAN_SEL_OUT & ~CHAN_MASK) == 4'h0;
  endproperty
  a_chan_width: assert property (p_chan_width) else $error("channel select wrong");

  property p_pin_mask;
    (PIN_ANALOG_EN_OUT & ~PIN_MASK) == 8'h00;
  endproperty
  a_pin_mask: assert property (p_pin_mask) else $error("absent pin enabled");

  property p_digital_off;
    PIN_DIGITAL_EN_OUT == ~PIN_ANALOG_EN_OUT;
  endproperty
  a_digital_off: assert property (p_digital_off) else $error("digital use on analog pin");

  property p_pullup_off;
    (PIN_PULLUP_EN_OUT & PIN_ANALOG_EN_OUT) == 8'h00;
  endproperty
  a_pullup_off: assert property (p_pullup_off) else $error("pull-high on analog pin");

  property p_start_rise;
    (REG_WR_IN && REG_ADDR_IN == adcc_pkg::OFF_CONTROL && REG_WDATA_IN[adcc_pkg::START_BIT] && !q.start)
      |=> q.run && CONV_RESET_OUT;
  endproperty
  a_start_rise: assert property (p_start_rise) else $error("start rise not handled");

  property p_flag_clear;
    (link.done && q.st == adcc_pkg::ST_CONV && !(d.start && !q.start)) |=> !q.run;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag still set after done");

  property p_same_cycle;
    $fell(q.run) |-> $past(link.done) && q.res == $past(link.code);
  endproperty
  a_same_cycle: assert property (p_same_cycle) else $error("flag and result split");

  c_start: cover property (q.st == adcc_pkg::ST_ARMED ##1 q.st == adcc_pkg::ST_CONV);
  c_done: cover property ($fell(q.run));
  c_irq: cover property (IRQ_OUT);
  c_read_low: cover property (REG_RD_IN && REG_ADDR_IN == adcc_pkg::OFF_RES_LOW && q.res != 12'h000);
endmodule

/* File: tb/test_adcc_top.sv */
// Self-checking testbench for the converter control block.
// Assumes the design package and the default wide variant; the comparator is modelled here.
`timescale 1ns/1ps
module test_adcc_top;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic sys_clk;
  logic sys_rst;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic comp;
  logic [11:0] dac_code;
  logic [3:0] chan_sel;
  logic conv_reset;
  logic power_off;
  logic ref_select;
  logic [7:0] pullup_cfg;
  logic [7:0] pin_analog;
  logic [7:0] pin_digital;
  logic [7:0] pin_pullup;
  logic irq;
  logic [11:0] target;
  logic [7:0] rd_val;
  int err_total;
  int checked;
  // ----------------------------------------------------------------
  // Design and comparator model
  // ----------------------------------------------------------------
  adcc_top dut
  (
    .SYS_CLK_IN(sys_clk),
    .SYS_RST_IN(sys_rst),
    .REG_ADDR_IN(reg_addr),
    .REG_WDATA_IN(reg_wdata),
    .REG_WR_IN(reg_wr),
    .REG_RD_IN(reg_rd),
    .REG_RDATA_OUT(reg_rdata),
    .COMP_IN(comp),
    .DAC_CODE_OUT(dac_code),
    .CHAN_SEL_OUT(chan_sel),
    .CONV_RESET_OUT(conv_reset),
    .CONV_POWER_OFF_OUT(power_off),
    .REF_SELECT_OUT(ref_select),
    .PULLUP_CFG_IN(pullup_cfg),
    .PIN_ANALOG_EN_OUT(pin_analog),
    .PIN_DIGITAL_EN_OUT(pin_digital),
    .PIN_PULLUP_EN_OUT(pin_pullup),
    .IRQ_OUT(irq)
  );
  // Comparator is high while the sampled input is at or above the trial code.
  assign comp = (dac_code <= target);
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    if (err_total == 0 && checked > 0)
    begin
      $display("ALL CHECKS OK");
    end
    else
    begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp, input string what);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask
  task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask
  task automatic check_reg(input logic [2:0] a, input logic [7:0] exp);
    reg_read(a, rd_val);
    cmp8(rd_val, exp, "register read");
  endtask
  task automatic convert(input logic [11:0] t, input logic [3:0] ch);
    int n;
    target <= t;
    reg_write(adcc_pkg::OFF_CONTROL, {4'h8, ch});
    @(negedge sys_clk);
    cmp1(conv_reset, 1'b1, "converter reset");
    check_reg(adcc_pkg::OFF_CONTROL, {4'hC, ch});
    reg_write(adcc_pkg::OFF_CONTROL, {4'h0, ch});
    n = 0;
    rd_val = 8'h40;
    while (rd_val[adcc_pkg::RUN_BIT] !== 1'b0 && n < 200)
    begin
      reg_read(adcc_pkg::OFF_CONTROL, rd_val);
      n++;
    end
    if (n >= 200)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: conversion never finished", $time);
      final_report();
    end
    cmp8(rd_val, {4'h0, ch}, "control after done");
    check_reg(adcc_pkg::OFF_RES_HIGH, t[11:4]);
    check_reg(adcc_pkg::OFF_RES_LOW, {t[3:0], 4'h0});
  endtask
  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  initial
  begin
    #1ms;
    err_total++;
    $display("CHECK FAILED at %0t: run did not finish", $time);
    final_report();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    err_total = 0;
    checked = 0;
    sys_rst = 1'b1;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    pullup_cfg = 8'hF0;
    target = 12'h000;
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    // Reset values.
    check_reg(adcc_pkg::OFF_CONTROL, 8'h40);
    check_reg(adcc_pkg::OFF_CLK_PWR, 8'h40);
    check_reg(adcc_pkg::OFF_PIN_EN, 8'h00);
    check_reg(3'h7, 8'h00);
    cmp1(power_off, 1'b1, "power off at reset");
    cmp8(pin_digital, 8'hFF, "digital enables at reset");
    cmp8(pin_pullup, 8'hF0, "pull-high at reset");
    // Pin analog enables.
    reg_write(adcc_pkg::OFF_PIN_EN, 8'hA5);
    @(negedge sys_clk);
    @(negedge sys_clk);
    cmp8(pin_analog, 8'hA5, "analog enables");
    cmp8(pin_digital, 8'h5A, "digital enables");
    cmp8(pin_pullup, 8'h50, "pull-high enables");
    check_reg(adcc_pkg::OFF_PIN_EN, 8'hA5);
    // Clock, power and reference fields.
    reg_write(adcc_pkg::OFF_CLK_PWR, 8'h27);
    check_reg(adcc_pkg::OFF_CLK_PWR, 8'h27);
    cmp1(ref_select, 1'b1, "reference select");
    cmp1(power_off, 1'b0, "power on");
    reg_write(adcc_pkg::OFF_CLK_PWR, 8'h00);
    // Conversions with interrupt enabled.
    reg_write(adcc_pkg::OFF_IRQ_MASK, 8'h01);
    convert(12'hABC, 4'h1);
    @(negedge sys_clk);
    cmp1(irq, 1'b1, "interrupt raised");
    check_reg(adcc_pkg::OFF_IRQ_STAT, 8'h01);
    cmp1(irq, 1'b0, "interrupt cleared by read");
    check_reg(adcc_pkg::OFF_IRQ_STAT, 8'h00);
    convert(12'hFFF, 4'h3);
    // Result bytes ignore writes.
    reg_write(adcc_pkg::OFF_RES_HIGH, 8'h00);
    reg_write(adcc_pkg::OFF_RES_LOW, 8'h5F);
    check_reg(adcc_pkg::OFF_RES_HIGH, 8'hFF);
    check_reg(adcc_pkg::OFF_RES_LOW, 8'hF0);
    check_reg(adcc_pkg::OFF_IRQ_STAT, 8'h01);
    // Masked interrupt stays low.
    reg_write(adcc_pkg::OFF_IRQ_MASK, 8'h00);
    convert(12'h001, 4'h4);
    @(negedge sys_clk);
    cmp1(irq, 1'b0, "masked interrupt");
    check_reg(adcc_pkg::OFF_IRQ_STAT, 8'h01);
    // Channel selection over the first five of the sixteen sources.
    for (int ch = 0; ch < 5; ch++)
    begin
      reg_write(adcc_pkg::OFF_CONTROL, 8'(ch));
      check_reg(adcc_pkg::OFF_CONTROL, 8'(ch));
      cmp8({4'h0, chan_sel}, 8'(ch), "channel select output");
    end
    final_report();
  end
endmodule
